// ---- logic/eeprom_front_consts.vh ----
// Summary of operation
// - Main array holds 256 bytes arranged as 16 pages of 16 bytes.
// - Programming cycle after a write finishes within 4 ms, byte or page.
// - A separate 16-byte identification page exists and can be locked read-only.
// - Works with bus clocks of 100 kHz, 400 kHz and up to 1 MHz.
// - Bus clock edges capture incoming bits and time outgoing bits.
// - Data line is only pulled low or released, never driven high.
// - Select code bits b3..b1 must equal the chip-select straps to respond.
// - An unconnected strap counts as logic 0.
// - With write protect high, no write reaches the memory.
// - With write protect low or floating, writes are allowed.
// - Under write protect, select and address are acknowledged, data bytes are not.
// - Stored data carries an error-correcting code, corrected on every read.
// - Type field 1010b selects the array, 1011b the identification page, others ignored.
// - Last select bit gives direction: 1 read, 0 write.
// - After each byte the receiver pulls data low in the ninth clock.
// - Stop after a write starts programming; starts are ignored meanwhile.
`ifndef EEPROM_FRONT_CONSTS_VH
`define EEPROM_FRONT_CONSTS_VH

`define TYPE_MAIN     4'hA
`define TYPE_ID       4'hB
`define MEM_BYTES     256
`define PAGE_BYTES    16
`define ID_BYTES      16
`define ECC_BITS      4
`define FIFO_WORDS    8
`define FIFO_WIDTH    17
`define PROG_TIME_US  4000
`define CORE_CLK_MHZ  250
`define PROG_CYC_BITS 20
`define BITS_PER_BYTE 4'h8

`endif

// ---- logic/byte_fifo.v ----
`timescale 1ns/1ns
`include "eeprom_front_consts.vh"
module byte_fifo #(
    parameter WIDTH = `FIFO_WIDTH,
    parameter DEPTH = `FIFO_WORDS,
    parameter AW    = 3
) (
    input  wire             core_clk,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] buf_q [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = buf_q[rd_q];

    // Storage needs no reset; pointers and count do.
    always @(posedge core_clk) begin
        if (push) begin
            buf_q[wr_q] <= in_data;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // byte_fifo

// ---- logic/eeprom_front.v ----
`timescale 1ns/1ns
`include "eeprom_front_consts.vh"
module eeprom_front #(
    parameter PROG_CYCLES = `PROG_TIME_US * `CORE_CLK_MHZ,
    parameter FIFO_DEPTH  = `FIFO_WORDS
) (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       scl_pin,
    input  wire       sda_in,
    input  wire [2:0] chip_select_straps,
    input  wire       write_protect_input,
    output reg        sda_out,
    output reg        sda_oe,
    output reg        prog_busy,
    output reg        id_locked
);
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_DEV   = 3'h1;
    localparam [2:0] S_ADDR  = 3'h2;
    localparam [2:0] S_WDATA = 3'h3;
    localparam [2:0] S_RDATA = 3'h4;
    localparam [2:0] S_DRAIN = 3'h5;
    localparam [2:0] S_PROG  = 3'h6;

    localparam integer              PROG_LAST_I = PROG_CYCLES - 1;
    localparam [`PROG_CYC_BITS-1:0] PROG_LAST   = PROG_LAST_I[`PROG_CYC_BITS-1:0];

    // Hamming check bits over the eight data bits.
    function [3:0] ecc_chk;
        input [7:0] d;
        begin
            ecc_chk[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
            ecc_chk[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
            ecc_chk[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
            ecc_chk[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
        end
    endfunction

    // Corrects a single flipped data bit from the syndrome.
    function [7:0] ecc_fix;
        input [7:0] d;
        input [3:0] c;
        reg   [3:0] s;
        begin
            s = ecc_chk(d) ^ c;
            case (s)
                4'h3:    ecc_fix = d ^ 8'h01;
                4'h5:    ecc_fix = d ^ 8'h02;
                4'h6:    ecc_fix = d ^ 8'h04;
                4'h7:    ecc_fix = d ^ 8'h08;
                4'h9:    ecc_fix = d ^ 8'h10;
                4'hA:    ecc_fix = d ^ 8'h20;
                4'hB:    ecc_fix = d ^ 8'h40;
                4'hC:    ecc_fix = d ^ 8'h80;
                default: ecc_fix = d;
            endcase
        end
    endfunction

    // Input synchronisers.
    reg       scl_m;
    reg       scl_s;
    reg       scl_d;
    reg       sda_m;
    reg       sda_s;
    reg       sda_d;
    reg [2:0] cs_m;
    reg [2:0] cs_s;
    reg       wp_m;
    reg       wp_s;

    // Protocol state.
    reg [2:0]                state_q;
    reg [3:0]                bcnt_q;
    reg                      in_ack_q;
    reg [7:0]                sh_q;
    reg [7:0]                tx_q;
    reg [7:0]                addr_q;
    reg                      id_sel_q;
    reg                      lock_op_q;
    reg                      wr_pend_q;
    reg                      lock_pend_q;
    reg [`PROG_CYC_BITS-1:0] prog_cnt_q;
    reg                      commit_q;
    reg [15:0]               mask_q;
    reg [3:0]                lat_page_q;
    reg                      lat_id_q;

    // Arrays hold data plus check bits; the page latch holds data only.
    reg [`ECC_BITS+7:0] mem_q [0:`MEM_BYTES-1];
    reg [`ECC_BITS+7:0] idm_q [0:`ID_BYTES-1];
    reg [7:0]           lat_q [0:`PAGE_BYTES-1];

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_ev  = scl_s & scl_d & ~sda_d & sda_s;
    wire busy     = (state_q == S_DRAIN) | (state_q == S_PROG);
    wire byte_end = scl_fall & ~in_ack_q & (bcnt_q == `BITS_PER_BYTE);

    wire type_ok   = (sh_q[7:4] == `TYPE_MAIN) | (sh_q[7:4] == `TYPE_ID);
    wire dev_match = type_ok & (sh_q[3:1] == cs_s);

    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [16:0] fifo_out;
    wire        fifo_pop = fifo_out_valid & (state_q != S_PROG) & ~commit_q;
    wire        data_ok  = ~wp_s & ~(id_sel_q & id_locked)
                         & (lock_op_q | fifo_in_ready);
    wire        push     = byte_end & (state_q == S_WDATA) & data_ok & ~lock_op_q;

    wire [`ECC_BITS+7:0] rd_word = id_sel_q ? idm_q[addr_q[3:0]] : mem_q[addr_q];
    wire [7:0]           rd_byte = ecc_fix(rd_word[7:0], rd_word[`ECC_BITS+7:8]);
    wire [7:0]           page_inc = {addr_q[7:4], addr_q[3:0] + 4'h1};
    wire [7:0]           next_addr = id_sel_q ? page_inc : addr_q + 8'h01;

    byte_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   ({id_sel_q, addr_q, sh_q}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out)
    );

    // Bus pins are sampled by two flops; floating straps and protect read low.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
            cs_m  <= 3'h0;
            cs_s  <= 3'h0;
            wp_m  <= 1'b0;
            wp_s  <= 1'b0;
        end else begin
            scl_m <= scl_pin;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_d <= sda_s;
            cs_m  <= chip_select_straps;
            cs_s  <= cs_m;
            wp_m  <= write_protect_input;
            wp_s  <= wp_m;
        end
    end

    // Page latch and array updates; the arrays themselves have no reset.
    integer i;
    always @(posedge core_clk) begin
        if (fifo_pop) begin
            lat_q[fifo_out[11:8]] <= fifo_out[7:0];
        end
        if (commit_q) begin
            for (i = 0; i < `PAGE_BYTES; i = i + 1) begin
                if (mask_q[i]) begin
                    if (lat_id_q) begin
                        idm_q[i] <= {ecc_chk(lat_q[i]), lat_q[i]};
                    end else begin
                        mem_q[{lat_page_q, i[3:0]}] <= {ecc_chk(lat_q[i]), lat_q[i]};
                    end
                end
            end
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= S_IDLE;
            bcnt_q      <= 4'h0;
            in_ack_q    <= 1'b0;
            sh_q        <= 8'h00;
            tx_q        <= 8'h00;
            addr_q      <= 8'h00;
            id_sel_q    <= 1'b0;
            lock_op_q   <= 1'b0;
            wr_pend_q   <= 1'b0;
            lock_pend_q <= 1'b0;
            prog_cnt_q  <= {`PROG_CYC_BITS{1'b0}};
            commit_q    <= 1'b0;
            mask_q      <= 16'h0000;
            lat_page_q  <= 4'h0;
            lat_id_q    <= 1'b0;
            sda_out     <= 1'b0;
            sda_oe      <= 1'b0;
            prog_busy   <= 1'b0;
            id_locked   <= 1'b0;
        end else begin
            sda_out  <= 1'b0;
            commit_q <= 1'b0;
            if (fifo_pop) begin
                mask_q[fifo_out[11:8]] <= 1'b1;
                lat_page_q             <= fifo_out[15:12];
                lat_id_q               <= fifo_out[16];
            end
            if (commit_q) begin
                mask_q <= 16'h0000;
            end
            if (busy) begin
                sda_oe <= 1'b0;
                if (state_q == S_DRAIN) begin
                    if (!fifo_out_valid) begin
                        state_q    <= S_PROG;
                        prog_cnt_q <= {`PROG_CYC_BITS{1'b0}};
                        prog_busy  <= 1'b1;
                    end
                end else if (prog_cnt_q == PROG_LAST) begin
                    commit_q    <= 1'b1;
                    id_locked   <= id_locked | lock_pend_q;
                    wr_pend_q   <= 1'b0;
                    lock_pend_q <= 1'b0;
                    prog_busy   <= 1'b0;
                    state_q     <= S_IDLE;
                end else begin
                    prog_cnt_q <= prog_cnt_q + 1'b1;
                end
            end else if (start_ev) begin
                state_q     <= S_DEV;
                bcnt_q      <= 4'h0;
                in_ack_q    <= 1'b0;
                sda_oe      <= 1'b0;
                wr_pend_q   <= 1'b0;
                lock_pend_q <= 1'b0;
            end else if (stop_ev) begin
                sda_oe   <= 1'b0;
                in_ack_q <= 1'b0;
                if ((state_q == S_WDATA) && (wr_pend_q || lock_pend_q)) begin
                    state_q <= S_DRAIN;
                end else begin
                    state_q <= S_IDLE;
                end
            end else if (state_q != S_IDLE) begin
                if (scl_rise) begin
                    if (in_ack_q) begin
                        if ((state_q == S_RDATA) && !sda_oe) begin
                            if (sda_s) begin
                                state_q <= S_IDLE;
                            end else begin
                                addr_q <= next_addr;
                            end
                        end
                    end else if (bcnt_q != `BITS_PER_BYTE) begin
                        sh_q   <= {sh_q[6:0], sda_s};
                        tx_q   <= {tx_q[6:0], 1'b0};
                        bcnt_q <= bcnt_q + 4'h1;
                    end
                end else if (scl_fall) begin
                    if (in_ack_q) begin
                        in_ack_q <= 1'b0;
                        bcnt_q   <= 4'h0;
                        if (state_q == S_RDATA) begin
                            tx_q   <= rd_byte;
                            sda_oe <= ~rd_byte[7];
                        end else begin
                            sda_oe <= 1'b0;
                        end
                    end else if (bcnt_q == `BITS_PER_BYTE) begin
                        in_ack_q <= 1'b1;
                        sda_oe   <= 1'b0;
                        case (state_q)
                            S_DEV: begin
                                if (dev_match) begin
                                    sda_oe   <= 1'b1;
                                    id_sel_q <= (sh_q[7:4] == `TYPE_ID);
                                    state_q  <= sh_q[0] ? S_RDATA : S_ADDR;
                                end else begin
                                    state_q <= S_IDLE;
                                end
                            end
                            S_ADDR: begin
                                sda_oe    <= 1'b1;
                                addr_q    <= sh_q;
                                lock_op_q <= id_sel_q & sh_q[7];
                                state_q   <= S_WDATA;
                            end
                            S_WDATA: begin
                                if (data_ok) begin
                                    sda_oe <= 1'b1;
                                    if (lock_op_q) begin
                                        lock_pend_q <= 1'b1;
                                    end else begin
                                        wr_pend_q <= 1'b1;
                                        addr_q    <= page_inc;
                                    end
                                end
                            end
                            default: begin
                                sda_oe <= 1'b0;
                            end
                        endcase
                    end else if (state_q == S_RDATA) begin
                        sda_oe <= ~tx_q[7];
                    end
                end
            end
        end
    end
endmodule // eeprom_front

// ---- test/eeprom_front_sva.sv ----
`timescale 1ns/1ns
module eeprom_front_sva #(
    parameter PROG_CYCLES = 200
) (
    input wire       core_clk,
    input wire       rst_n,
    input wire       scl_pin,
    input wire       sda_in,
    input wire [2:0] chip_select_straps,
    input wire       write_protect_input,
    input wire       sda_out,
    input wire       sda_oe,
    input wire       prog_busy,
    input wire       id_locked
);
    reg [31:0] busy_cnt_q;
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= prog_busy ? busy_cnt_q + 32'h1 : 32'h0;
        end
    end
    sda_low_only_a: assert property (sda_out == 1'b0)
        else $error("data driven high");
    ack_at_low_a: assert property ($rose(sda_oe) |->
        !$past(scl_pin, 2) && !$past(scl_pin, 3)) else $error("pull began in clock high");
    release_at_low_a: assert property ($fell(sda_oe) |->
        !$past(scl_pin, 2) && !$past(scl_pin, 3)) else $error("release in clock high");
    busy_quiet_a: assert property (prog_busy |-> !sda_oe)
        else $error("bus answered while programming");
    prog_time_a: assert property ($fell(prog_busy) |->
        busy_cnt_q <= PROG_CYCLES && busy_cnt_q + 1 >= PROG_CYCLES) else $error("bad busy time");
    lock_sticky_a: assert property (id_locked |=> id_locked)
        else $error("lock cleared");
    protect_block_a: assert property ($rose(prog_busy) |-> !$past(write_protect_input, 4))
        else $error("programming under protect");
    reset_idle_a: assert property ($rose(rst_n) |-> !sda_oe && !prog_busy && !id_locked)
        else $error("outputs active after reset");
endmodule // eeprom_front_sva

bind eeprom_front eeprom_front_sva #(.PROG_CYCLES(PROG_CYCLES)) i_sva (
    .core_clk(core_clk), .rst_n(rst_n), .scl_pin(scl_pin), .sda_in(sda_in),
    .chip_select_straps(chip_select_straps), .write_protect_input(write_protect_input),
    .sda_out(sda_out), .sda_oe(sda_oe), .prog_busy(prog_busy), .id_locked(id_locked)
);

// ---- test/i2c_master_model.sv ----
`timescale 1ns/1ns
module i2c_master_model (
    input  wire core_clk,
    input  wire sda_line,
    output reg  scl,
    output reg  m_oe
);
    initial begin
        scl = 1'b1;
        m_oe = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        m_oe <= !b;
        tick(3);
        scl <= 1'b1;
        tick(3);
        r = sda_line;
        tick(3);
        scl <= 1'b0;
        tick(3);
    endtask
    task automatic start_cond();
        m_oe <= 1'b0;
        tick(3);
        scl <= 1'b1;
        tick(6);
        m_oe <= 1'b1;
        tick(6);
        scl <= 1'b0;
        tick(3);
    endtask
    task automatic stop_cond();
        m_oe <= 1'b1;
        tick(3);
        scl <= 1'b1;
        tick(6);
        m_oe <= 1'b0;
        tick(6);
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic get_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!more, r);
    endtask
endmodule // i2c_master_model

// ---- test/eeprom_front_bench.sv ----
`timescale 1ns/1ns
module eeprom_front_bench;
    localparam int PROG = 200;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [2:0] straps = 3'h0;
    logic       wp = 1'b0;
    logic [7:0] mem [256];
    logic [7:0] idp [16];
    int         fail_count = 0;
    int         checks_done = 0;
    int         seed = 47;
    wire        scl;
    wire        m_oe;
    wire        sda_out;
    wire        sda_oe;
    wire        prog_busy;
    wire        id_locked;
    wire        sda_line = (m_oe || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

    always #2 core_clk = ~core_clk;

    eeprom_front #(.PROG_CYCLES(PROG), .FIFO_DEPTH(8)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .scl_pin(scl), .sda_in(sda_line),
        .chip_select_straps(straps), .write_protect_input(wp), .sda_out(sda_out),
        .sda_oe(sda_oe), .prog_busy(prog_busy), .id_locked(id_locked)
    );
    i2c_master_model i_master (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .m_oe(m_oe));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [7:0] sel(input logic [3:0] t, input logic [2:0] cs, input logic rw);
        return {t, cs, rw};
    endfunction
    task automatic send(input logic [7:0] d, input logic exp, input string what);
        logic ack;
        i_master.put_byte(d, ack);
        check(what, {7'h0, ack}, {7'h0, exp});
    endtask
    task automatic wait_prog(input logic poll);
        int n;
        for (n = 0; n < 100 && prog_busy !== 1'b1; n++) @(posedge core_clk);
        check("prog_busy", {7'h0, prog_busy}, 8'h1);
        if (prog_busy !== 1'b1) finish_test();
        if (poll) begin
            i_master.start_cond();
            send(sel(4'hA, straps, 1'b0), 1'b0, "busy_sel");
            i_master.stop_cond();
        end
        for (n = 0; n < PROG + 50 && prog_busy !== 1'b0; n++) @(posedge core_clk);
        check("prog_done", {7'h0, prog_busy}, 8'h0);
        if (prog_busy !== 1'b0) finish_test();
    endtask
    task automatic wr(input logic [3:0] t, input logic [7:0] a, input int n, input logic ok,
                      input logic poll);
        logic [7:0] d;
        i_master.start_cond();
        send(sel(t, straps, 1'b0), 1'b1, "wsel");
        send(a, 1'b1, "waddr");
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            send(d, ok, "wdata");
            if (ok && t == 4'hA) mem[{a[7:4], 4'(a[3:0] + i)}] = d;
            if (ok && t == 4'hB && !a[7]) idp[4'(a[3:0] + i)] = d;
        end
        i_master.stop_cond();
        if (ok) wait_prog(poll);
    endtask
    task automatic rdq(input logic [3:0] t, input logic [7:0] a, input int n);
        logic [7:0] d;
        i_master.start_cond();
        send(sel(t, straps, 1'b0), 1'b1, "rsel");
        send(a, 1'b1, "raddr");
        i_master.start_cond();
        send(sel(t, straps, 1'b1), 1'b1, "rsel2");
        for (int i = 0; i < n; i++) begin
            i_master.get_byte(i < n - 1, d);
            check("rdata", d, t == 4'hA ? mem[8'(a + i)] : idp[4'(a[3:0] + i)]);
        end
        i_master.stop_cond();
    endtask

    initial begin
        logic [2:0] cs;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        wr(4'hA, 8'hFE, 9, 1'b1, 1'b1);
        wr(4'hA, 8'h00, 1, 1'b1, 1'b0);
        rdq(4'hA, 8'hFE, 3);
        rdq(4'hA, 8'hF0, 2);
        @(posedge core_clk);
        straps <= 3'($random(seed));
        for (int t = 0; t < 16; t++) begin
            cs = (t == 10 || t == 11) ? straps ^ 3'(t + 1) : straps;
            i_master.start_cond();
            send(sel(4'(t), cs, 1'($random(seed))), 1'b0, "bad_sel");
            send(sel(4'hA, straps, 1'b0), 1'b0, "after_bad");
            i_master.stop_cond();
        end
        wp <= 1'b1;
        wr(4'hA, 8'h00, 2, 1'b0, 1'b0);
        wp <= 1'b0;
        rdq(4'hA, 8'h00, 1);
        wr(4'hB, 8'h05, 2, 1'b1, 1'b0);
        rdq(4'hB, 8'h05, 2);
        wr(4'hB, 8'h80, 1, 1'b1, 1'b0);
        repeat (2) @(posedge core_clk);
        check("id_locked", {7'h0, id_locked}, 8'h1);
        wr(4'hB, 8'h05, 1, 1'b0, 1'b0);
        rdq(4'hB, 8'h05, 1);
        finish_test();
    end
endmodule // eeprom_front_bench
